//--- hw/cellbal_defs.svh
// Timing counts, field codes and reset values for the cell balance and protector block.
// Assumes a single 100 MHz system clock.
`ifndef CELLBAL_DEFS_SVH
`define CELLBAL_DEFS_SVH

`define CLK_PERIOD_NS     10
`define BAL_TICK_NS       1000000
`define BAL_TICK_CYC      ((`BAL_TICK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PROT_SLOT_NS      2000
`define PROT_SLOT_CYC     ((`PROT_SLOT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BIST_NS           100000
`define BIST_CYC          ((`BIST_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SETTLE_NS         50000
`define SETTLE_CYC        ((`SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define MODE_STOP         2'b00
`define MODE_ROUND_ROBIN  2'b01
`define MODE_BIST         2'b10
`define MODE_LOCK         2'b11
`define ACT_SHUTDOWN      2'b10

`define TIME_INVALID      8'hff
`define ADC_BIST_CODE     16'h8000
`define NUM_CHAN          16

`endif

//--- hw/cellbal_pkg.sv
// Types shared by the cell balance and protector block.
// Assumes the constants header is compiled alongside.
package cellbal_pkg;

	typedef struct packed
	{
		logic       host_pause_bit;
		logic       stop_on_fault_enable;
		logic       thermistor_pause_enable;
		logic [1:0] completion_power_action;
	} bal_ctrl_t;

	typedef struct packed
	{
		logic [7:0] overvoltage_threshold;
		logic [7:0] undervoltage_threshold;
		logic [7:0] balance_done_voltage_threshold;
		logic [1:0] voltage_protector_mode;
		logic [3:0] protector_channel_lock;
		logic [3:0] active_cell_count;
		logic [7:0] undervoltage_mask_low;
		logic [7:0] undervoltage_mask_high;
	} prot_cfg_t;

	typedef struct packed
	{
		logic balance_complete_flag;
		logic in_pause_flag;
		logic fault_abort_flag;
	} bal_status_t;

	typedef struct packed
	{
		logic ov;
		logic uv;
		logic done;
	} cmp_t;

	typedef enum logic [2:0] {B_IDLE, B_RUN, B_PAUSE, B_DONE, B_ABORT} bal_state_t;
	typedef enum logic [1:0] {P_STOP, P_SCAN, P_BIST} prot_state_t;

endpackage : cellbal_pkg

//--- hw/cell_balance_protect.sv
// Cell balancing timers, pause and stop control, and the cell voltage protector sequencer.
// Assumes window comparators answer for the channel on comparator_channel, and that
// host configuration arrives as steady levels with go commands as one-cycle strobes.
`timescale 1ns/10ps
`include "cellbal_defs.svh"

module cell_balance_protect
#(
	parameter int unsigned TICK_CYCLES  = `BAL_TICK_CYC,
	parameter int unsigned BIST_CYCLES  = `BIST_CYC,
	parameter int unsigned SETTLE_CYCLES = `SETTLE_CYC
)
(
	// Clock and reset
	input  wire logic                     clk_sys,
	input  wire logic                     reset,
	// Host commands and configuration
	input  wire logic                     device_active,
	input  wire logic                     shutdown_now,
	input  wire logic                     balance_go,
	input  wire logic                     time_readback_go,
	input  wire logic [3:0]               time_readback_channel_select,
	input  wire logic                     voltage_protector_go,
	input  wire logic                     fault_clear,
	input  wire logic                     fault_unmasked,
	input  wire cellbal_pkg::bal_ctrl_t   balance_control_reg,
	input  wire logic [15:0][7:0]         channel_balance_timer_setting,
	input  wire cellbal_pkg::prot_cfg_t   voltage_protector_control,
	// Status
	output logic                          voltage_protector_running,
	output cellbal_pkg::bal_status_t      balance_status_reg,
	output logic [7:0]                    remaining_time_reg,
	output logic [7:0]                    overvoltage_fault_low,
	output logic [7:0]                    overvoltage_fault_high,
	output logic [7:0]                    undervoltage_fault_low,
	output logic [7:0]                    undervoltage_fault_high,
	output logic [1:0]                    power_mode_request,
	output logic                          power_mode_request_valid,
	// Analog side
	input  wire logic                     die_temp_warning,
	input  wire logic                     thermistor_over,
	input  wire cellbal_pkg::cmp_t        comparator_result,
	output logic [3:0]                    comparator_channel,
	output cellbal_pkg::prot_cfg_t        comparator_setting,
	output logic                          comparator_bist,
	output logic [15:0]                   balancing_switch,
	// ADC interplay
	input  wire logic                     adc_running,
	output logic                          adc_result_hold,
	output logic                          adc_result_force,
	output logic [15:0]                   adc_forced_code
);
	import cellbal_pkg::*;

	function automatic logic chan_enabled(input logic [3:0] ch, input logic [3:0] top);
		return ch <= top;
	endfunction : chan_enabled

	// ****************************************
	// Pin synchronisers
	// ****************************************
	// Order: die warning, thermistor, ov, uv, done
	logic [4:0] sync1, sync2, sync3, filt, next_filt;

	always_comb
	begin
		next_filt = filt;
		for (int i = 0; i < 5; i++)
			if (sync2[i] == sync3[i])
				next_filt[i] = sync3[i];
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			sync1 <= 5'h00;
			sync2 <= 5'h00;
			sync3 <= 5'h00;
			filt  <= 5'h00;
		end
		else
		begin
			sync1 <= {die_temp_warning, thermistor_over, comparator_result};
			sync2 <= sync1;
			sync3 <= sync2;
			filt  <= next_filt;
		end
	end

	// ****************************************
	// Voltage protector sequencer
	// ****************************************
	prot_state_t pstate, next_pstate;
	prot_cfg_t   next_pcfg;
	logic [7:0]  slot, next_slot;
	logic [3:0]  chan, next_chan;
	logic [31:0] bist_cnt, next_bist_cnt;
	logic [15:0] ovf, next_ovf, uvf, next_uvf, below, next_below;
	logic        slot_end, bist_end;
	logic [15:0] uv_mask;

	// Undervoltage mask as one word, bit n for channel n
	assign uv_mask  = {comparator_setting.undervoltage_mask_high,
		comparator_setting.undervoltage_mask_low};
	assign slot_end = (slot == 8'(`PROT_SLOT_CYC - 1));
	assign bist_end = (pstate == P_BIST) && (bist_cnt == 32'(BIST_CYCLES - 1));

	always_comb
	begin
		next_pstate   = pstate;
		next_pcfg     = comparator_setting;
		next_slot     = slot;
		next_chan     = chan;
		next_bist_cnt = bist_cnt;
		next_ovf      = fault_clear ? 16'h0000 : ovf;
		next_uvf      = fault_clear ? 16'h0000 : uvf;
		next_below    = below;
		case (pstate)
			P_SCAN:
			begin
				next_slot = slot_end ? 8'h00 : 8'(slot + 8'h01);
				if (slot_end)
				begin
					// Inactive channels are scanned but their results dropped
					if (chan_enabled(chan, comparator_setting.active_cell_count))
					begin
						if (filt[2])
							next_ovf[chan] = 1'b1;
						if (filt[1] && !uv_mask[chan])
							next_uvf[chan] = 1'b1;
						next_below[chan] = filt[0];
					end
					if (comparator_setting.voltage_protector_mode == `MODE_LOCK)
						next_chan = comparator_setting.protector_channel_lock;
					else
						next_chan = 4'(chan + 4'h1);
				end
			end
			P_BIST:
			begin
				next_bist_cnt = 32'(bist_cnt + 32'h1);
				if (bist_end)
					next_pstate = P_STOP;
			end
			default:
				next_pstate = P_STOP;
		endcase
		if (voltage_protector_go && device_active)
		begin
			next_pcfg     = voltage_protector_control;
			next_slot     = 8'h00;
			next_bist_cnt = 32'h0;
			next_below    = 16'h0000;
			next_chan     = 4'h0;
			case (voltage_protector_control.voltage_protector_mode)
				`MODE_ROUND_ROBIN: next_pstate = P_SCAN;
				`MODE_BIST:        next_pstate = P_BIST;
				`MODE_LOCK:
				begin
					next_pstate = P_SCAN;
					next_chan   = voltage_protector_control.protector_channel_lock;
				end
				default:           next_pstate = P_STOP;
			endcase
		end
		if (shutdown_now)
			next_pstate = P_STOP;
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			pstate                    <= P_STOP;
			comparator_setting        <= '0;
			slot                      <= 8'h00;
			chan                      <= 4'h0;
			bist_cnt                  <= 32'h0;
			ovf                       <= 16'h0000;
			uvf                       <= 16'h0000;
			below                     <= 16'h0000;
			voltage_protector_running <= 1'b0;
			comparator_channel        <= 4'h0;
			comparator_bist           <= 1'b0;
			overvoltage_fault_low     <= 8'h00;
			overvoltage_fault_high    <= 8'h00;
			undervoltage_fault_low    <= 8'h00;
			undervoltage_fault_high   <= 8'h00;
		end
		else
		begin
			pstate                    <= next_pstate;
			comparator_setting        <= next_pcfg;
			slot                      <= next_slot;
			chan                      <= next_chan;
			bist_cnt                  <= next_bist_cnt;
			ovf                       <= next_ovf;
			uvf                       <= next_uvf;
			below                     <= next_below;
			voltage_protector_running <= (next_pstate != P_STOP);
			comparator_channel        <= next_chan;
			comparator_bist           <= (next_pstate == P_BIST);
			overvoltage_fault_low     <= next_ovf[7:0];
			overvoltage_fault_high    <= next_ovf[15:8];
			undervoltage_fault_low    <= next_uvf[7:0];
			undervoltage_fault_high   <= next_uvf[15:8];
		end
	end

	capture_go_a: assert property (@(posedge clk_sys) disable iff (reset)
		voltage_protector_go && device_active && !shutdown_now |=>
		voltage_protector_running == ($past(voltage_protector_control.voltage_protector_mode)
		!= `MODE_STOP) && comparator_setting == $past(voltage_protector_control))
		else $error("protector go did not capture settings");

	// ****************************************
	// Balancing timers and state
	// ****************************************
	bal_state_t       bstate, next_bstate;
	logic [15:0][7:0] timer, next_timer;
	logic [15:0]      active, next_active;
	logic [31:0]      tick, next_tick;
	logic [7:0]       next_rem;
	logic             next_complete, next_abort, pause_cause, all_zero;

	assign pause_cause = filt[4] || (balance_control_reg.thermistor_pause_enable && filt[3])
		|| balance_control_reg.host_pause_bit;

	always_comb
	begin
		all_zero = 1'b1;
		for (int i = 0; i < `NUM_CHAN; i++)
			if (channel_balance_timer_setting[i] != 8'h00)
				all_zero = 1'b0;
	end

	always_comb
	begin
		next_bstate   = bstate;
		next_timer    = timer;
		next_active   = active;
		next_tick     = tick;
		next_complete = balance_status_reg.balance_complete_flag;
		next_abort    = balance_status_reg.fault_abort_flag;
		next_rem      = remaining_time_reg;
		case (bstate)
			B_RUN:
			begin
				if (balance_control_reg.stop_on_fault_enable && fault_unmasked)
				begin
					next_bstate = B_ABORT;
					next_active = 16'h0000;
					next_abort  = 1'b1;
				end
				else if (pause_cause)
					next_bstate = B_PAUSE;
				else
				begin
					next_tick = (tick == 32'(TICK_CYCLES - 1)) ? 32'h0 : 32'(tick + 32'h1);
					for (int i = 0; i < `NUM_CHAN; i++)
					begin
						if (active[i] && tick == 32'(TICK_CYCLES - 1))
						begin
							next_timer[i] = 8'(timer[i] - 8'h01);
							if (timer[i] == 8'h01)
								next_active[i] = 1'b0;
						end
						// Voltage stop leaves the timer at the time that was left
						if (below[i])
							next_active[i] = 1'b0;
					end
					if (next_active == 16'h0000)
					begin
						next_bstate   = B_DONE;
						next_complete = 1'b1;
					end
				end
			end
			// Fault input is not looked at here, so a pause can never abort
			B_PAUSE:
				if (!pause_cause)
					next_bstate = B_RUN;
			B_IDLE, B_DONE, B_ABORT:
				next_bstate = bstate;
			default:
				next_bstate = B_IDLE;
		endcase
		if (balance_go && device_active)
		begin
			next_tick     = 32'h0;
			next_complete = 1'b0;
			next_abort    = 1'b0;
			next_timer    = channel_balance_timer_setting;
			for (int i = 0; i < `NUM_CHAN; i++)
				next_active[i] = (channel_balance_timer_setting[i] != 8'h00);
			next_bstate   = all_zero ? B_IDLE : B_RUN;
		end
		if (shutdown_now)
		begin
			next_bstate = B_IDLE;
			next_active = 16'h0000;
		end
		if (time_readback_go)
			next_rem = (bstate == B_IDLE) ? `TIME_INVALID
				: timer[time_readback_channel_select];
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			bstate                   <= B_IDLE;
			timer                    <= '0;
			active                   <= 16'h0000;
			tick                     <= 32'h0;
			balance_status_reg       <= '0;
			remaining_time_reg       <= `TIME_INVALID;
			balancing_switch         <= 16'h0000;
			power_mode_request       <= 2'b00;
			power_mode_request_valid <= 1'b0;
		end
		else
		begin
			bstate                   <= next_bstate;
			timer                    <= next_timer;
			active                   <= next_active;
			tick                     <= next_tick;
			balance_status_reg       <= '{next_complete, next_bstate == B_PAUSE, next_abort};
			remaining_time_reg       <= next_rem;
			balancing_switch         <= (next_bstate == B_RUN) ? next_active : 16'h0000;
			power_mode_request       <= (next_bstate == B_DONE && bstate != B_DONE)
				? balance_control_reg.completion_power_action : power_mode_request;
			power_mode_request_valid <= (next_bstate == B_DONE && bstate != B_DONE);
		end
	end

	switch_off_a: assert property (@(posedge clk_sys) disable iff (reset)
		bstate != B_RUN |-> balancing_switch == 16'h0000 &&
		balance_status_reg.in_pause_flag == (bstate == B_PAUSE))
		else $error("switches on outside run or pause flag wrong");

	timer_hold_a: assert property (@(posedge clk_sys) disable iff (reset)
		bstate == B_PAUSE && !balance_go |=> $stable(timer))
		else $error("timers moved while paused");

	pause_noabort_a: assert property (@(posedge clk_sys) disable iff (reset)
		bstate == B_PAUSE && fault_unmasked |=> bstate != B_ABORT)
		else $error("fault aborted balancing during pause");

	fault_abort_a: assert property (@(posedge clk_sys) disable iff (reset)
		bstate == B_RUN && balance_control_reg.stop_on_fault_enable && fault_unmasked
		&& !(balance_go && device_active) && !shutdown_now |=>
		bstate == B_ABORT && balance_status_reg.fault_abort_flag &&
		!balance_status_reg.balance_complete_flag && balancing_switch == 16'h0000)
		else $error("fault did not abort balancing");

	zero_go_a: assert property (@(posedge clk_sys) disable iff (reset)
		balance_go && device_active && all_zero |=> bstate == B_IDLE
		&& !balance_status_reg.balance_complete_flag)
		else $error("all zero go started balancing");

	complete_all_a: assert property (@(posedge clk_sys) disable iff (reset)
		// Shutdown returns to idle but leaves the completion flag standing
		balance_status_reg.balance_complete_flag |-> active == 16'h0000 &&
		(bstate == B_DONE || bstate == B_IDLE))
		else $error("complete flag with channels still armed");

	power_act_a: assert property (@(posedge clk_sys) disable iff (reset)
		bstate != B_DONE ##1 bstate == B_DONE |-> power_mode_request_valid &&
		power_mode_request == $past(balance_control_reg.completion_power_action))
		else $error("completion power request missing");

	invalid_time_a: assert property (@(posedge clk_sys) disable iff (reset)
		time_readback_go && bstate == B_IDLE |=> remaining_time_reg == `TIME_INVALID)
		else $error("readback not invalid while stopped");

	// ****************************************
	// ADC hold during protector BIST
	// ****************************************
	logic [31:0] settle, next_settle;
	logic        was_running, next_was_running, block;

	assign block = (pstate == P_BIST) || (settle != 32'h0);

	always_comb
	begin
		next_settle      = (settle != 32'h0) ? 32'(settle - 32'h1) : settle;
		next_was_running = was_running;
		if (bist_end)
			next_settle = 32'(SETTLE_CYCLES);
		if (pstate != P_BIST && next_pstate == P_BIST)
		begin
			next_was_running = adc_running;
			next_settle      = 32'h0;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			settle           <= 32'h0;
			was_running      <= 1'b0;
			adc_result_hold  <= 1'b0;
			adc_result_force <= 1'b0;
			adc_forced_code  <= 16'h0000;
		end
		else
		begin
			settle           <= next_settle;
			was_running      <= next_was_running;
			adc_result_hold  <= block && was_running;
			adc_result_force <= block && !was_running && adc_running;
			adc_forced_code  <= `ADC_BIST_CODE;
		end
	end

	bist_adc_a: assert property (@(posedge clk_sys) disable iff (reset)
		pstate == P_BIST && adc_running |=> adc_result_hold || adc_result_force)
		else $error("adc results not blocked during bist");

endmodule : cell_balance_protect

//--- tb/cell_stack_model.sv
// Window comparator model standing in for the analog cell stack.
// Assumes the block names the channel and the captured settings to compare.
`timescale 1ns/10ps

module cell_stack_model
	import cellbal_pkg::*;
(
	// Stack voltages
	input  wire logic [15:0][7:0]       cell_v,
	// Comparator side
	input  wire logic [3:0]             comparator_channel,
	input  wire cellbal_pkg::prot_cfg_t comparator_setting,
	output cellbal_pkg::cmp_t           comparator_result
);
	logic [7:0] v;

	// Answers follow the channel at once; the block does its own filtering
	always_comb
	begin
		v = cell_v[comparator_channel];
		comparator_result.ov   = v > comparator_setting.overvoltage_threshold;
		comparator_result.uv   = v < comparator_setting.undervoltage_threshold;
		comparator_result.done = v < comparator_setting.balance_done_voltage_threshold;
	end
endmodule : cell_stack_model

//--- tb/tb.sv
// Self-checking bench for the cell balance and protector block.
// Assumes short tick, self-test and settle counts set through parameters.
`timescale 1ns/10ps

module tb;
	import cellbal_pkg::*;

	logic clk_sys = 1'b0, reset = 1'b1, device_active = 1'b1, shutdown_now = 1'b0;
	logic balance_go = 1'b0, time_readback_go = 1'b0, voltage_protector_go = 1'b0;
	logic fault_clear = 1'b0, fault_unmasked = 1'b0, die_temp_warning = 1'b0;
	logic thermistor_over = 1'b0, adc_running = 1'b0;
	logic [3:0] sel = 4'h0;
	bal_ctrl_t ctl = '0;
	prot_cfg_t cfg = '0;
	logic [15:0][7:0] tmr = '0;
	logic [15:0][7:0] cell_v = {16{8'h80}};
	logic prun, pmv, cbist, hold, force_c;
	bal_status_t st;
	logic [7:0] rt, ovl, ovh, uvl, uvh, v, w;
	logic [1:0] pmr;
	cmp_t cres;
	logic [3:0] cch;
	prot_cfg_t cset;
	logic [15:0] sw, fcode;
	logic seen;
	int n_fail = 0, comparisons = 0, i, k;

	always #5 clk_sys = ~clk_sys;

	cell_balance_protect #(.TICK_CYCLES(4), .BIST_CYCLES(8), .SETTLE_CYCLES(4)) dut (
		.clk_sys(clk_sys), .reset(reset), .device_active(device_active),
		.shutdown_now(shutdown_now), .balance_go(balance_go),
		.time_readback_go(time_readback_go), .time_readback_channel_select(sel),
		.voltage_protector_go(voltage_protector_go), .fault_clear(fault_clear),
		.fault_unmasked(fault_unmasked), .balance_control_reg(ctl),
		.channel_balance_timer_setting(tmr), .voltage_protector_control(cfg),
		.voltage_protector_running(prun), .balance_status_reg(st),
		.remaining_time_reg(rt), .overvoltage_fault_low(ovl),
		.overvoltage_fault_high(ovh), .undervoltage_fault_low(uvl),
		.undervoltage_fault_high(uvh), .power_mode_request(pmr),
		.power_mode_request_valid(pmv), .die_temp_warning(die_temp_warning),
		.thermistor_over(thermistor_over), .comparator_result(cres),
		.comparator_channel(cch), .comparator_setting(cset), .comparator_bist(cbist),
		.balancing_switch(sw), .adc_running(adc_running), .adc_result_hold(hold),
		.adc_result_force(force_c), .adc_forced_code(fcode));

	cell_stack_model stack (.cell_v(cell_v), .comparator_channel(cch),
		.comparator_setting(cset), .comparator_result(cres));

	// ****************************************
	// Access tasks
	// ****************************************
	task automatic step(input int n);
		repeat (n) @(negedge clk_sys);
	endtask : step

	task automatic check(input string what, input logic [15:0] seen_v, input logic [15:0] exp);
		comparisons++;
		if (seen_v !== exp)
		begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen_v);
		end
	endtask : check

	task automatic go_bal;
		balance_go = 1'b1;
		step(1);
		balance_go = 1'b0;
	endtask : go_bal

	task automatic go_prot;
		voltage_protector_go = 1'b1;
		step(1);
		voltage_protector_go = 1'b0;
	endtask : go_prot

	task automatic rb(input logic [3:0] ch, output logic [7:0] val);
		sel = ch;
		time_readback_go = 1'b1;
		step(1);
		time_readback_go = 1'b0;
		step(1);
		val = rt;
	endtask : rb

	task automatic wrap_up;
		$display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : wrap_up

	initial
	begin
		#200000;
		n_fail++;
		wrap_up();
	end

	// ****************************************
	// Test sequence
	// ****************************************
	initial
	begin
		step(3);
		reset = 1'b0;
		step(1);
		check("rt_reset", rt, 8'hff);
		rb(4'd0, v);
		check("rt_never", v, 8'hff);
		tmr[0] = 8'd2;
		tmr[1] = 8'd3;
		device_active = 1'b0;
		go_bal();
		step(2);
		check("sw_sleep_go", sw, 16'h0000);
		device_active = 1'b1;
		ctl.completion_power_action = 2'b10;
		go_bal();
		step(1);
		check("sw_run", sw, 16'h0003);
		device_active = 1'b0;
		ctl.host_pause_bit = 1'b1;
		step(2);
		check("sw_pause", sw, 16'h0000);
		check("in_pause", st.in_pause_flag, 1'b1);
		rb(4'h1, v);
		check("rt_pause", v, 8'h03);
		step(20);
		rb(4'd1, w);
		check("rt_frozen", w, v);
		ctl.host_pause_bit = 1'b0;
		step(2);
		check("sw_resume", sw[1], 1'b1);
		seen = 1'b0;
		for (i = 0; i < 200 && st.balance_complete_flag !== 1'b1; i++)
		begin
			seen |= (pmv === 1'b1);
			step(1);
		end
		seen |= (pmv === 1'b1);
		check("complete", st.balance_complete_flag, 1'b1);
		check("pm_pulse", seen, 1'b1);
		check("pm_code", pmr, 2'b10);
		check("sw_done", sw, 16'h0000);
		rb(4'd0, v);
		check("rt_expired", v, 8'h00);
		device_active = 1'b1;
		tmr = '0;
		tmr[4] = 8'd60;
		ctl.stop_on_fault_enable = 1'b1;
		go_bal();
		step(1);
		for (k = 0; k < 2; k++)
		begin
			die_temp_warning = (k == 0);
			thermistor_over = (k == 1);
			ctl.thermistor_pause_enable = (k == 1);
			step(8);
			check("cause_pause", st.in_pause_flag, 1'b1);
			check("cause_sw", sw, 16'h0000);
			fault_unmasked = 1'b1;
			step(3);
			check("no_abort", st.fault_abort_flag, 1'b0);
			fault_unmasked = 1'b0;
			die_temp_warning = 1'b0;
			thermistor_over = 1'b0;
			step(8);
			check("cause_resume", sw, 16'h0010);
		end
		fault_unmasked = 1'b1;
		step(2);
		check("abort", st.fault_abort_flag, 1'b1);
		check("abort_done", st.balance_complete_flag, 1'b0);
		check("abort_sw", sw, 16'h0000);
		fault_unmasked = 1'b0;
		rb(4'd4, v);
		check("rt_abort", v !== 8'hff && v !== 8'h00, 1'b1);
		tmr = '0;
		go_bal();
		step(1);
		check("zero_sw", sw, 16'h0000);
		check("zero_done", st.balance_complete_flag, 1'b0);
		rb(4'd4, v);
		check("rt_zero", v, 8'hff);
		cfg.overvoltage_threshold = 8'hc0;
		cfg.undervoltage_threshold = 8'h40;
		cfg.voltage_protector_mode = 2'b11;
		cfg.protector_channel_lock = 4'd3;
		cfg.active_cell_count = 4'd15;
		cell_v[3] = 8'hd0;
		go_prot();
		step(1);
		check("run_lock", prun, 1'b1);
		check("lock_ch", cch, 4'd3);
		step(450);
		check("ov_lock", ovl, 8'h08);
		cell_v[3] = 8'h80;
		step(1);
		fault_clear = 1'b1;
		step(1);
		fault_clear = 1'b0;
		cfg.voltage_protector_mode = 2'b01;
		cfg.balance_done_voltage_threshold = 8'hff;
		cfg.active_cell_count = 4'd13;
		cfg.undervoltage_mask_high = 8'h10;
		cell_v[5] = 8'h30;
		cell_v[12] = 8'h30;
		cell_v[14] = 8'hd0;
		go_prot();
		cfg.overvoltage_threshold = 8'h00;
		step(3700);
		check("ov_rr", {ovh, ovl}, 16'h0000);
		check("cap_ov", cset.overvoltage_threshold, 8'hc0);
		check("uv_rr", {uvh, uvl}, 16'h0020);
		tmr[2] = 8'd50;
		go_bal();
		step(10);
		check("vstop_done", st.balance_complete_flag, 1'b1);
		rb(4'd2, v);
		check("rt_vstop", v, 8'h32);
		cfg.voltage_protector_mode = 2'b10;
		adc_running = 1'b1;
		go_prot();
		step(3);
		check("bist", cbist, 1'b1);
		check("adc_hold", hold, 1'b1);
		step(30);
		check("hold_end", hold, 1'b0);
		check("bist_end", prun, 1'b0);
		adc_running = 1'b0;
		go_prot();
		step(2);
		adc_running = 1'b1;
		step(2);
		check("adc_force", force_c, 1'b1);
		check("adc_code", fcode, 16'h8000);
		adc_running = 1'b0;
		step(30);
		cfg.voltage_protector_mode = 2'h1;
		go_prot();
		step(2);
		check("mode_rr", prun, 1'b1);
		cfg.voltage_protector_mode = 2'h0;
		go_prot();
		step(2);
		check("mode_stop", prun, 1'b0);
		cfg.voltage_protector_mode = 2'h1;
		go_prot();
		shutdown_now = 1'b1;
		step(2);
		shutdown_now = 1'b0;
		check("sd_prot", prun, 1'b0);
		rb(4'd2, v);
		check("rt_shutdown", v, 8'hff);
		wrap_up();
	end
endmodule : tb
